// ---- src/csb_unit.sv ----
// counted short-branch execution unit
// How it works
// RULE1: opcodes E2, E1 and E0 select the plain, zero-set and zero-clear counted branch, each with a displacement byte.
// RULE2: the selected count is decremented first and the new value is tested for zero.
// RULE3: a 32-bit address size uses the full count, otherwise only its low 16 bits.
// RULE4: the displacement is a signed byte, sign-extended and added to the instruction pointer.
// RULE5: reachable distance is -128 to +127 bytes from the instruction pointer.
// RULE6: the plain form branches whenever the new count is nonzero.
// RULE7: the zero-set form branches only on nonzero count and zero flag one.
// RULE8: the zero-clear form branches only on nonzero count and zero flag zero.
// RULE9: a branch not taken continues at the next instruction.
// RULE10: no status flag is altered.
// RULE11: with 16-bit operand size the new pointer keeps only its low 16 bits.
// RULE12: in protected mode a target beyond the code limit raises a protection fault with error code zero.
// RULE13: a taken branch that does not fault issues one line fetch, or two when the target's offset in its 32-byte line is above 15.
// RULE14: real and virtual-8086 modes raise no fault here.
// RULE15: the displacement is added to the pointer already past this instruction.
`include "csb_params.svh"
module csb_unit (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                issue_valid,
  output logic                     issue_ready,
  input  wire logic [7:0]          opcode,
  input  wire logic [7:0]          short_displacement,
  input  wire logic [31:0]         instr_pointer,
  input  wire logic [31:0]         count_reg_32,
  input  wire logic                addr_size_32,
  input  wire logic                op_size_32,
  input  wire logic                zero_flag,
  input  wire logic                protected_mode,
  input  wire logic                v86_mode,
  input  wire logic [31:0]         cs_limit,
  output logic                     done,
  output logic                     illegal_op,
  output logic                     count_we,
  output logic [31:0]              count_new,
  output logic                     branch_taken,
  output logic [31:0]              next_ip,
  output logic                     fetch_req,
  input  wire logic                fetch_ack,
  output logic [31:0]              fetch_addr,
  output logic                     general_protection_fault,
  output logic [15:0]              fault_code,
  output logic                     flags_we
);
  import csb_pkg::*;

  // ************************************************
  // decode and target
  // ************************************************
  csb_form_t   form;
  logic [31:0] target;
  logic        beyond_limit;

  csb_decode u_dec (
    .opcode (opcode),
    .form   (form)
  );

  csb_target u_tgt (
    .instr_pointer      (instr_pointer),
    .short_displacement (short_displacement),
    .op_size_32         (op_size_32),
    .cs_limit           (cs_limit),
    .target             (target),
    .beyond_limit       (beyond_limit)
  );

  function automatic logic [1:0] line_count(input logic [31:0] addr);
    // a fetch that starts past mid-line also pulls the following line
    line_count = (addr[4:0] > 5'h0F) ? `CSB_FETCH_LINES_MAX : `CSB_FETCH_LINES_MIN;
  endfunction : line_count

  // ************************************************
  // combinational evaluation
  // ************************************************
  logic [31:0] dec_count;
  logic        count_nz;
  logic        take;
  always_comb begin
    if (addr_size_32) begin
      dec_count = count_reg_32 - 32'h00000001;  // see RULE2 see RULE3
      count_nz  = (dec_count != 32'h00000000);
    end else begin
      dec_count = {count_reg_32[31:16], count_reg_32[15:0] - 16'h0001};  // see RULE3
      count_nz  = (dec_count[15:0] != 16'h0000);
    end
    case (form)
      CSB_FORM_COUNT: take = count_nz;                // see RULE6
      CSB_FORM_ZSET:  take = count_nz & zero_flag;    // see RULE7
      CSB_FORM_ZCLR:  take = count_nz & ~zero_flag;   // see RULE8
      default:        take = 1'b0;
    endcase
  end

  // ************************************************
  // sequencer
  // ************************************************
  csb_state_t  state_ff,  nxt_state;
  logic        done_ff,   nxt_done;
  logic        ill_ff,    nxt_ill;
  logic        cwe_ff,    nxt_cwe;
  logic [31:0] cnt_ff,    nxt_cnt;
  logic        tkn_ff,    nxt_tkn;
  logic [31:0] nip_ff,    nxt_nip;
  logic        freq_ff,   nxt_freq;
  logic [31:0] faddr_ff,  nxt_faddr;
  logic [1:0]  flines_ff, nxt_flines;
  logic        gpf_ff,    nxt_gpf;

  always_comb begin
    nxt_state  = state_ff;
    nxt_done   = 1'b0;
    nxt_ill    = 1'b0;
    nxt_cwe    = 1'b0;
    nxt_cnt    = cnt_ff;
    nxt_tkn    = tkn_ff;
    nxt_nip    = nip_ff;
    nxt_freq   = freq_ff;
    nxt_faddr  = faddr_ff;
    nxt_flines = flines_ff;
    nxt_gpf    = 1'b0;
    case (state_ff)
      CSB_IDLE: begin
        if (issue_valid) begin
          if (form == CSB_FORM_NONE) begin
            nxt_ill  = 1'b1;
            nxt_done = 1'b1;
          end else if (take && protected_mode && !v86_mode && beyond_limit) begin
            nxt_gpf   = 1'b1;  // see RULE12 see RULE14
            nxt_done  = 1'b1;
            nxt_tkn   = 1'b0;
            nxt_nip   = instr_pointer;
            nxt_state = CSB_FAULT;
          end else begin
            nxt_cwe = 1'b1;
            nxt_cnt = dec_count;
            nxt_tkn = take;
            nxt_nip = take ? target : instr_pointer;  // see RULE9
            if (take) begin
              nxt_freq   = 1'b1;  // see RULE13
              nxt_faddr  = target;
              nxt_flines = line_count(target);
              nxt_state  = CSB_FETCH;
            end else begin
              nxt_done  = 1'b1;
              nxt_state = CSB_EXEC;
            end
          end
        end
      end
      CSB_FETCH: begin
        if (fetch_ack) begin
          if (flines_ff == `CSB_FETCH_LINES_MAX) begin
            nxt_flines = `CSB_FETCH_LINES_MIN;
            nxt_faddr  = {faddr_ff[31:5], 5'h00} + 32'(`CSB_LINE_BYTES);
          end else begin
            nxt_freq  = 1'b0;
            nxt_done  = 1'b1;
            nxt_state = CSB_EXEC;
          end
        end
      end
      CSB_EXEC:  nxt_state = CSB_IDLE;
      CSB_FAULT: nxt_state = CSB_IDLE;
      default:   nxt_state = CSB_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff  <= CSB_IDLE;
      done_ff   <= 1'b0;
      ill_ff    <= 1'b0;
      cwe_ff    <= 1'b0;
      cnt_ff    <= 32'h00000000;
      tkn_ff    <= 1'b0;
      nip_ff    <= 32'h00000000;
      freq_ff   <= 1'b0;
      faddr_ff  <= 32'h00000000;
      flines_ff <= `CSB_FETCH_LINES_MIN;
      gpf_ff    <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      done_ff   <= nxt_done;
      ill_ff    <= nxt_ill;
      cwe_ff    <= nxt_cwe;
      cnt_ff    <= nxt_cnt;
      tkn_ff    <= nxt_tkn;
      nip_ff    <= nxt_nip;
      freq_ff   <= nxt_freq;
      faddr_ff  <= nxt_faddr;
      flines_ff <= nxt_flines;
      gpf_ff    <= nxt_gpf;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign issue_ready              = (state_ff == CSB_IDLE);
  assign done                     = done_ff;
  assign illegal_op               = ill_ff;
  assign count_we                 = cwe_ff;
  assign count_new                = cnt_ff;
  assign branch_taken             = tkn_ff;
  assign next_ip                  = nip_ff;
  assign fetch_req                = freq_ff;
  assign fetch_addr               = faddr_ff;
  assign general_protection_fault = gpf_ff;
  assign fault_code               = `CSB_FAULT_CODE_ZERO;
  assign flags_we                 = 1'b0;  // see RULE10
endmodule : csb_unit

// ---- src/csb_params.svh ----
// constants for the counted short-branch unit
`ifndef CSB_PARAMS_SVH
`define CSB_PARAMS_SVH
`define CSB_OP_COUNT_ONLY   8'hE2
`define CSB_OP_IF_ZERO_SET  8'hE1
`define CSB_OP_IF_ZERO_CLR  8'hE0
`define CSB_LOW16_MASK      32'h0000FFFF
`define CSB_DISP_MIN        (-128)
`define CSB_DISP_MAX        127
`define CSB_FETCH_LINES_MIN 2'h1
`define CSB_FETCH_LINES_MAX 2'h2
`define CSB_LINE_BYTES      32
`define CSB_FAULT_CODE_ZERO 16'h0000
`endif

// ---- src/csb_pkg.sv ----
// types for the counted short-branch unit
package csb_pkg;
  typedef enum logic [3:0] {
    CSB_IDLE  = 4'h1,
    CSB_EXEC  = 4'h2,
    CSB_FETCH = 4'h4,
    CSB_FAULT = 4'h8
  } csb_state_t;
  typedef enum logic [1:0] {
    CSB_FORM_COUNT = 2'h0,
    CSB_FORM_ZSET  = 2'h1,
    CSB_FORM_ZCLR  = 2'h2,
    CSB_FORM_NONE  = 2'h3
  } csb_form_t;
endpackage : csb_pkg

// ---- src/csb_decode.sv ----
// opcode decoder for the counted short-branch family
`include "csb_params.svh"
module csb_decode (
  input  wire logic [7:0]         opcode,
  output csb_pkg::csb_form_t      form
);
  import csb_pkg::*;
  always_comb begin
    case (opcode)
      `CSB_OP_COUNT_ONLY:  form = CSB_FORM_COUNT;  // see RULE1
      `CSB_OP_IF_ZERO_SET: form = CSB_FORM_ZSET;
      `CSB_OP_IF_ZERO_CLR: form = CSB_FORM_ZCLR;
      default:             form = CSB_FORM_NONE;
    endcase
  end
endmodule : csb_decode

// ---- src/csb_target.sv ----
// branch target arithmetic and limit test
`include "csb_params.svh"
module csb_target (
  input  wire logic [31:0] instr_pointer,
  input  wire logic [7:0]  short_displacement,
  input  wire logic        op_size_32,
  input  wire logic [31:0] cs_limit,
  output logic      [31:0] target,
  output logic             beyond_limit
);
  logic [31:0] sum;
  always_comb begin
    // ip already points past the instruction; 8-bit signed only
    sum = instr_pointer + {{24{short_displacement[7]}}, short_displacement};  // see RULE4 see RULE5 see RULE15
    target = op_size_32 ? sum : (sum & `CSB_LOW16_MASK);  // see RULE11
    beyond_limit = (target > cs_limit);
  end
endmodule : csb_target

// ---- verif/csb_unit_monitor.sv ----
// checker for the counted short-branch unit
module csb_unit_monitor (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        issue_valid,
  input wire logic        issue_ready,
  input wire logic [7:0]  opcode,
  input wire logic        zero_flag,
  input wire logic        done,
  input wire logic        illegal_op,
  input wire logic        count_we,
  input wire logic        branch_taken,
  input wire logic        fetch_req,
  input wire logic        fetch_ack,
  input wire logic        general_protection_fault,
  input wire logic [15:0] fault_code,
  input wire logic        flags_we
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire take_in = issue_valid && issue_ready;
  property p_flags; flags_we == 1'b0; endproperty
  a_flags: assert property (p_flags) else $error("flags written");
  property p_code; general_protection_fault |-> fault_code == 16'h0000; endproperty
  a_code: assert property (p_code) else $error("fault code nonzero");
  property p_gpf; general_protection_fault |-> done && !branch_taken && !count_we; endproperty
  a_gpf: assert property (p_gpf) else $error("fault with side effects");
  property p_ill; take_in && (opcode > 8'hE2 || opcode < 8'hE0) |=> done && illegal_op; endproperty
  a_ill: assert property (p_ill) else $error("bad opcode not refused");
  property p_zset; take_in && opcode == 8'hE1 && !zero_flag |=> !fetch_req && done; endproperty
  a_zset: assert property (p_zset) else $error("zero-set form branched");
  property p_zclr; take_in && opcode == 8'hE0 && zero_flag |=> !fetch_req && done; endproperty
  a_zclr: assert property (p_zclr) else $error("zero-clear form branched");
  property p_hold; fetch_req && !fetch_ack |=> fetch_req; endproperty
  a_hold: assert property (p_hold) else $error("fetch dropped early");
  property p_end; $fell(fetch_req) |-> done && branch_taken; endproperty
  a_end: assert property (p_end) else $error("fetch end without done");
  property p_rose; $rose(fetch_req) |-> branch_taken && !done; endproperty
  a_rose: assert property (p_rose) else $error("fetch without branch");
  cover property (done && branch_taken);
  cover property (general_protection_fault);
  cover property (illegal_op);
endmodule : csb_unit_monitor

bind csb_unit csb_unit_monitor mon_u (.clock(clock), .rst_n(rst_n), .issue_valid(issue_valid),
  .issue_ready(issue_ready), .opcode(opcode), .zero_flag(zero_flag), .done(done), .illegal_op(illegal_op),
  .count_we(count_we), .branch_taken(branch_taken), .fetch_req(fetch_req), .fetch_ack(fetch_ack),
  .general_protection_fault(general_protection_fault), .fault_code(fault_code), .flags_we(flags_we));

// ---- verif/csb_fetch_model.sv ----
// instruction fetch responder, one ack per line after a chosen delay
module csb_fetch_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       fetch_req,
  input  wire logic [1:0] delay,
  output logic            fetch_ack
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] wait_ff;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fetch_ack <= 1'b0;
      wait_ff   <= 2'h0;
    end else begin
      fetch_ack <= 1'b0;
      if (fetch_req && !fetch_ack) begin
        if (wait_ff == 2'h0) begin
          fetch_ack <= 1'b1;
          wait_ff   <= delay;
        end else begin
          wait_ff <= wait_ff - 2'h1;
        end
      end
    end
  end
endmodule : csb_fetch_model

// ---- verif/csb_unit_tb_top.sv ----
// self-checking bench for the counted short-branch unit
module csb_unit_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rst_n, issue_valid, issue_ready, addr_size_32, op_size_32, zero_flag, protected_mode, v86_mode;
  logic done, illegal_op, count_we, branch_taken, fetch_req, fetch_ack, general_protection_fault, flags_we;
  logic [7:0] opcode, short_displacement;
  logic [31:0] instr_pointer, count_reg_32, cs_limit, count_new, next_ip, fetch_addr, st;
  logic [15:0] fault_code;
  logic [1:0] dly;
  int num_errors, samples_checked;
  csb_unit dut_u (.clock(clock), .rst_n(rst_n), .issue_valid(issue_valid), .issue_ready(issue_ready),
    .opcode(opcode), .short_displacement(short_displacement), .instr_pointer(instr_pointer),
    .count_reg_32(count_reg_32), .addr_size_32(addr_size_32), .op_size_32(op_size_32), .zero_flag(zero_flag),
    .protected_mode(protected_mode), .v86_mode(v86_mode), .cs_limit(cs_limit), .done(done),
    .illegal_op(illegal_op), .count_we(count_we), .count_new(count_new), .branch_taken(branch_taken),
    .next_ip(next_ip), .fetch_req(fetch_req), .fetch_ack(fetch_ack), .fetch_addr(fetch_addr),
    .general_protection_fault(general_protection_fault), .fault_code(fault_code), .flags_we(flags_we));
  csb_fetch_model fm_u (.clock(clock), .rst_n(rst_n), .fetch_req(fetch_req), .delay(dly), .fetch_ack(fetch_ack));
  function automatic logic [31:0] xs();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction : xs
  // returns {take, fault, new count, target}
  function automatic logic [65:0] expect_of();
    logic [31:0] c, t;
    logic z, tk;
    c = addr_size_32 ? count_reg_32 - 32'h1 : {count_reg_32[31:16], count_reg_32[15:0] - 16'h1};
    z = addr_size_32 ? (c == 32'h0) : (c[15:0] == 16'h0);
    tk = !z && (opcode == 8'hE2 || (opcode == 8'hE1 && zero_flag) || (opcode == 8'hE0 && !zero_flag));
    t = instr_pointer + {{24{short_displacement[7]}}, short_displacement};
    if (!op_size_32) t = t & 32'h0000FFFF;
    return {tk, tk && protected_mode && !v86_mode && t > cs_limit, c, t};
  endfunction : expect_of
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task end_sim();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task run_one(input int i);
    logic [31:0] r;
    logic [65:0] e;
    logic ok, br;
    int lines, n;
    @(negedge clock);
    r = xs();
    opcode = (i % 9 == 4) ? r[15:8] : {6'h38, r[5:4]};
    short_displacement = i < 8 ? (i[2] ? (i[1] ? 8'hFF : 8'h00) : (i[1] ? 8'h7F : 8'h80)) : r[23:16];
    count_reg_32 = i < 8 ? (i[0] ? 32'h1 : 32'h00010001) : xs() & (r[24] ? 32'h3 : 32'hFFFFFFFF);
    {addr_size_32, op_size_32, zero_flag, protected_mode, v86_mode} = r[29:25];
    instr_pointer = xs();
    cs_limit = r[30] ? xs() : 32'hFFFFFFFF;
    dly = r[9:8];
    issue_valid = 1'b1;
    e = expect_of();
    br = e[65] && !e[64];
    do begin ok = issue_ready; @(negedge clock); end while (ok !== 1'b1);
    issue_valid = 1'b0;
    check(count_we, (opcode <= 8'hE2 && opcode >= 8'hE0) && !e[64]);
    lines = 0;
    n = 0;
    while (done !== 1'b1 && n < 50) begin
      // first line starts at the target, a second one at the next 32-byte line
      if (fetch_req & fetch_ack)
        check(fetch_addr, lines == 0 ? e[31:0] : {e[31:5], 5'h00} + 32'h00000020);
      lines += (fetch_req & fetch_ack);
      n++;
      @(negedge clock);
    end
    check(done, 1);
    check(illegal_op, opcode > 8'hE2 || opcode < 8'hE0);
    if (opcode <= 8'hE2 && opcode >= 8'hE0) begin
      check(general_protection_fault, e[64]);
      check(branch_taken, br);
      check(next_ip, br ? e[31:0] : instr_pointer);
      if (!e[64]) check(count_new, e[63:32]);
      check(32'(lines), br ? (e[4:0] > 5'h0F ? 2 : 1) : 0);
    end
  endtask : run_one
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    #300000;
    num_errors++;
    end_sim();
  end
  initial begin
    st = 32'h0000224F;
    {rst_n, issue_valid, addr_size_32, op_size_32, zero_flag, protected_mode, v86_mode} = 7'h0;
    {opcode, short_displacement, instr_pointer, count_reg_32, cs_limit, dly} = '0;
    num_errors = 0;
    samples_checked = 0;
    repeat (20) @(posedge clock);
    @(negedge clock) rst_n = 1'b1;
    for (int i = 0; i < 400; i++) run_one(i);
    end_sim();
  end
endmodule : csb_unit_tb_top
